// ### boot_load_and_irq_routing.sv
// boot loader, register arbiter and interrupt router of the embedded controller
`timescale 1ns/1ns
module boot_load_and_irq_routing #(
    parameter int IRQ_N     = boot_pkg::IRQ_N,
    parameter int RAM_BYTES = boot_pkg::RAM_BYTES
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    input  wire logic                   clk_en,
    input  wire logic                   boot_memory_present,
    input  wire logic                   core_off,
    input  wire logic                   mode_standalone,
    input  wire logic                   core_standby,
    input  wire logic                   scl_i,
    output logic                        scl_o,
    output logic                        scl_oe_n,
    input  wire logic                   sda_i,
    output logic                        sda_o,
    output logic                        sda_oe_n,
    input  wire logic [11:0]            fetch_addr,
    input  wire logic [7:0]             rom_rd_data,
    output logic [7:0]                  fetch_data,
    output logic                        rom_en,
    output logic                        core_rst_n,
    output logic                        core_tick,
    output logic                        boot_done,
    output logic                        boot_fail,
    input  wire logic                   ctrl_req,
    input  wire logic                   ctrl_we,
    input  wire logic [15:0]            ctrl_addr,
    input  wire logic [7:0]             ctrl_wdata,
    output logic                        ctrl_gnt,
    input  wire logic                   ext_req,
    input  wire logic                   ext_we,
    input  wire logic [15:0]            ext_addr,
    input  wire logic [7:0]             ext_wdata,
    output logic                        ext_gnt,
    output logic                        ext_err,
    output logic                        reg_en,
    output logic                        reg_we,
    output logic [15:0]                 reg_addr,
    output logic [7:0]                  reg_wdata,
    input  wire logic [IRQ_N-1:0]       irq_src,
    input  wire logic [IRQ_N-1:0]       irq_enable,
    input  wire logic [IRQ_N-1:0]       irq_route_ext,
    input  wire logic [IRQ_N-1:0]       ctrl_irq_clr,
    input  wire logic [IRQ_N-1:0]       ext_irq_clr,
    output logic                        core_irq,
    output logic                        ext_irq,
    output logic                        core_run
);
    localparam int          CNT_W  = $clog2(RAM_BYTES);
    localparam int          QDIV_W = $clog2(boot_pkg::QTR_CYC);
    localparam logic [CNT_W-1:0]  CNT_LAST = CNT_W'(RAM_BYTES - 1);
    localparam logic [QDIV_W-1:0] QDIV_LAST = QDIV_W'(boot_pkg::QTR_CYC - 1);
    localparam logic [5:0]  ACC_MOD = 6'(boot_pkg::CLK_HZ * 8 / boot_pkg::CORE_HZ);
    localparam logic [5:0]  ACC_INC = 6'(8);

    function automatic logic is_private(input logic [15:0] a);
        is_private = (a & boot_pkg::PRIV_MASK) == boot_pkg::PRIV_BASE;
    endfunction

    boot_pkg::i2c_st_e     st_q;
    logic [QDIV_W-1:0]     qdiv_q;
    logic [1:0]            q_q;
    logic [2:0]            bit_q;
    logic [7:0]            sh_q;
    logic [1:0]            hdr_q;
    logic [CNT_W-1:0]      cnt_q;
    logic                  present_q;
    logic                  fail_q;
    logic [7:0]            ram [RAM_BYTES];
    logic [5:0]            acc_q;
    logic                  last_ext_q;
    logic [IRQ_N-1:0]      pend_q;
    logic                  tick;
    logic                  last_byte;
    logic                  ext_priv;
    logic                  pick_ext;
    logic [IRQ_N-1:0]      to_ext;
    logic [IRQ_N-1:0]      pend_d;

    assign tick      = qdiv_q == QDIV_LAST;
    assign last_byte = cnt_q == CNT_LAST;
    assign scl_o     = 1'b0;
    assign sda_o     = 1'b0;

    // quarter-bit timebase of the boot master
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            qdiv_q <= '0;
        end else if (clk_en) begin
            qdiv_q <= tick ? '0 : qdiv_q + 1'b1;
        end
    end

    // boot master: header write, repeated start, sequential read into RAM
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_q      <= boot_pkg::ST_IDLE;
            q_q       <= boot_pkg::Q_SET;
            bit_q     <= boot_pkg::BIT_MSB;
            sh_q      <= 8'h00;
            hdr_q     <= boot_pkg::HDR_HI;
            cnt_q     <= '0;
            present_q <= 1'b0;
            fail_q    <= 1'b0;
            scl_oe_n  <= 1'b1;
            sda_oe_n  <= 1'b1;
            boot_done <= 1'b0;
        end else if (clk_en && tick) begin
            q_q <= q_q + 1'b1;
            unique case (st_q)
                boot_pkg::ST_IDLE: begin
                    q_q       <= boot_pkg::Q_SET;
                    present_q <= boot_memory_present;
                    sh_q      <= {boot_pkg::EEPROM_ADDR, boot_pkg::I2C_WR};
                    st_q      <= boot_memory_present ? boot_pkg::ST_START
                                                     : boot_pkg::ST_DONE;
                end
                boot_pkg::ST_START: begin
                    unique case (q_q)
                        boot_pkg::Q_SET:  sda_oe_n <= 1'b1;
                        boot_pkg::Q_RISE: scl_oe_n <= 1'b1;
                        boot_pkg::Q_SAMP: sda_oe_n <= 1'b0;
                        boot_pkg::Q_FALL: begin
                            scl_oe_n <= 1'b0;
                            bit_q    <= boot_pkg::BIT_MSB;
                            st_q     <= boot_pkg::ST_WBYTE;
                        end
                    endcase
                end
                boot_pkg::ST_WBYTE: begin
                    unique case (q_q)
                        boot_pkg::Q_SET:  sda_oe_n <= sh_q[7];
                        boot_pkg::Q_RISE: scl_oe_n <= 1'b1;
                        boot_pkg::Q_SAMP: ;
                        boot_pkg::Q_FALL: begin
                            scl_oe_n <= 1'b0;
                            sh_q     <= {sh_q[6:0], 1'b0};
                            bit_q    <= bit_q - 1'b1;
                            if (bit_q == 3'h0) begin
                                st_q <= boot_pkg::ST_WACK;
                            end
                        end
                    endcase
                end
                boot_pkg::ST_WACK: begin
                    unique case (q_q)
                        boot_pkg::Q_SET:  sda_oe_n <= 1'b1;
                        boot_pkg::Q_RISE: scl_oe_n <= 1'b1;
                        boot_pkg::Q_SAMP: fail_q   <= sda_i;
                        boot_pkg::Q_FALL: begin
                            scl_oe_n <= 1'b0;
                            bit_q    <= boot_pkg::BIT_MSB;
                            hdr_q    <= hdr_q + 1'b1;
                            if (fail_q) begin
                                st_q <= boot_pkg::ST_STOP;
                            end else begin
                                unique case (hdr_q)
                                    boot_pkg::HDR_HI: begin
                                        sh_q <= boot_pkg::IMG_BASE[15:8];
                                        st_q <= boot_pkg::ST_WBYTE;
                                    end
                                    boot_pkg::HDR_LO: begin
                                        sh_q <= boot_pkg::IMG_BASE[7:0];
                                        st_q <= boot_pkg::ST_WBYTE;
                                    end
                                    boot_pkg::HDR_RS: begin
                                        sh_q <= {boot_pkg::EEPROM_ADDR, boot_pkg::I2C_RD};
                                        st_q <= boot_pkg::ST_START;
                                    end
                                    boot_pkg::HDR_RD: st_q <= boot_pkg::ST_RBYTE;
                                endcase
                            end
                        end
                    endcase
                end
                boot_pkg::ST_RBYTE: begin
                    unique case (q_q)
                        boot_pkg::Q_SET:  sda_oe_n <= 1'b1;
                        boot_pkg::Q_RISE: scl_oe_n <= 1'b1;
                        boot_pkg::Q_SAMP: sh_q     <= {sh_q[6:0], sda_i};
                        boot_pkg::Q_FALL: begin
                            scl_oe_n <= 1'b0;
                            bit_q    <= bit_q - 1'b1;
                            if (bit_q == 3'h0) begin
                                st_q <= boot_pkg::ST_MACK;
                            end
                        end
                    endcase
                end
                boot_pkg::ST_MACK: begin
                    unique case (q_q)
                        boot_pkg::Q_SET:  sda_oe_n <= last_byte;   // nack ends the read
                        boot_pkg::Q_RISE: scl_oe_n <= 1'b1;
                        boot_pkg::Q_SAMP: ;
                        boot_pkg::Q_FALL: begin
                            scl_oe_n <= 1'b0;
                            bit_q    <= boot_pkg::BIT_MSB;
                            cnt_q    <= cnt_q + 1'b1;
                            st_q     <= last_byte ? boot_pkg::ST_STOP : boot_pkg::ST_RBYTE;
                        end
                    endcase
                end
                boot_pkg::ST_STOP: begin
                    unique case (q_q)
                        boot_pkg::Q_SET:  sda_oe_n <= 1'b0;
                        boot_pkg::Q_RISE: scl_oe_n <= 1'b1;
                        boot_pkg::Q_SAMP: sda_oe_n <= 1'b1;
                        boot_pkg::Q_FALL: st_q     <= boot_pkg::ST_DONE;
                    endcase
                end
                boot_pkg::ST_DONE: begin
                    q_q       <= boot_pkg::Q_SET;
                    boot_done <= 1'b1;
                end
                default: st_q <= boot_pkg::ST_IDLE;
            endcase
        end
    end

    // image store and fetch path
    always_ff @(posedge core_clk) begin
        if (clk_en && tick && st_q == boot_pkg::ST_RBYTE && q_q == boot_pkg::Q_FALL
                && bit_q == 3'h0) begin
            ram[cnt_q] <= sh_q;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fetch_data <= 8'h00;
            rom_en     <= 1'b1;
            core_rst_n <= 1'b0;
            boot_fail  <= 1'b0;
        end else if (clk_en) begin
            core_rst_n <= boot_done;
            boot_fail  <= boot_done && present_q && fail_q;
            rom_en     <= !(present_q && !fail_q);
            if (present_q && !fail_q && fetch_addr < 12'(RAM_BYTES)) begin
                fetch_data <= ram[fetch_addr[CNT_W-1:0]];
            end else begin
                fetch_data <= rom_en ? rom_rd_data : 8'h00;
            end
        end
    end

    // 8 MHz core enable from a fractional accumulator; off, reset or idle stops it
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            acc_q     <= 6'h00;
            core_tick <= 1'b0;
            core_run  <= 1'b0;
        end else if (clk_en) begin
            acc_q     <= (acc_q + ACC_INC >= ACC_MOD) ? acc_q + ACC_INC - ACC_MOD
                                                      : acc_q + ACC_INC;
            core_run  <= boot_done && !core_off
                      && !(core_standby && !(|(pend_d & ~to_ext)));
            core_tick <= core_run && (acc_q + ACC_INC >= ACC_MOD);
        end
    end

    // register arbiter: one grant per cycle, alternate on contention
    assign ext_priv = is_private(ext_addr);
    assign pick_ext = ext_req && (!ctrl_req || !last_ext_q);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            last_ext_q <= 1'b0;
            ctrl_gnt   <= 1'b0;
            ext_gnt    <= 1'b0;
            ext_err    <= 1'b0;
            reg_en     <= 1'b0;
            reg_we     <= 1'b0;
            reg_addr   <= 16'h0000;
            reg_wdata  <= 8'h00;
        end else if (clk_en) begin
            ctrl_gnt <= 1'b0;
            ext_gnt  <= 1'b0;
            ext_err  <= 1'b0;
            reg_en   <= 1'b0;
            if (pick_ext && !ext_gnt) begin
                last_ext_q <= 1'b1;
                ext_gnt    <= 1'b1;
                ext_err    <= ext_priv;
                reg_en     <= !ext_priv;
                reg_we     <= ext_we;
                reg_addr   <= ext_addr;
                reg_wdata  <= ext_wdata;
            end else if (ctrl_req && !ctrl_gnt) begin
                last_ext_q <= 1'b0;
                ctrl_gnt   <= 1'b1;
                reg_en     <= 1'b1;
                reg_we     <= ctrl_we;
                reg_addr   <= ctrl_addr;
                reg_wdata  <= ctrl_wdata;
            end
        end
    end

    // interrupt collection and routing; timer and charger lines are among irq_src
    assign to_ext = mode_standalone ? '0 : irq_route_ext;
    assign pend_d = (pend_q & ~(ctrl_irq_clr | ext_irq_clr))
                  | (irq_src & irq_enable);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pend_q   <= '0;
            core_irq <= 1'b0;
            ext_irq  <= 1'b0;
        end else if (clk_en) begin
            pend_q   <= pend_d;
            core_irq <= |(pend_d & ~to_ext);
            ext_irq  <= |(pend_d & to_ext);
        end
    end

    a_core_held: assert property (@(posedge core_clk) disable iff (!rst_n)
        !boot_done |=> !core_rst_n && !core_run)
        else $error("core left reset before boot done");
    a_rom_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && boot_done && present_q && !fail_q |=> !rom_en)
        else $error("rom enabled after ram boot");
    a_one_grant: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(ctrl_gnt && ext_gnt))
        else $error("two grants in one cycle");
    a_priv_hidden: assert property (@(posedge core_clk) disable iff (!rst_n)
        ext_gnt && ext_err |-> !reg_en)
        else $error("private access forwarded");
    a_loser_served: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && ctrl_req && ext_gnt |=> ctrl_gnt)
        else $error("stalled requester not served next");
    a_irq_gated: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && (irq_src & ~irq_enable & ~pend_q) != '0
        |=> (pend_q & $past(irq_src & ~irq_enable & ~pend_q)) == '0)
        else $error("disabled source latched");
    a_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && (irq_src & irq_enable) != '0
        |=> (pend_q & $past(irq_src & irq_enable)) == $past(irq_src & irq_enable))
        else $error("set lost to clear");
    a_standalone: assert property (@(posedge core_clk) disable iff (!rst_n)
        clk_en && mode_standalone |=> !ext_irq)
        else $error("external irq in stand-alone mode");
    a_tick_gap: assert property (@(posedge core_clk) disable iff (!rst_n)
        core_tick |=> !core_tick ##1 !core_tick)
        else $error("core tick faster than 8 MHz");
    a_dev_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_q == boot_pkg::ST_START && hdr_q == boot_pkg::HDR_HI
        |-> sh_q == {boot_pkg::EEPROM_ADDR, boot_pkg::I2C_WR})
        else $error("wrong eeprom address");
endmodule // boot_load_and_irq_routing

// ### boot_pkg.sv
// constants and types shared by the boot loader and interrupt router
package boot_pkg;
    localparam int          CLK_HZ      = 50_000_000;
    localparam int          CORE_HZ     = 8_000_000;
    localparam int          I2C_HZ      = 400_000;
    localparam int          QTR_CYC     = (CLK_HZ + 4 * I2C_HZ - 1) / (4 * I2C_HZ);
    localparam int          RAM_BYTES   = 1536;
    localparam int          ROM_BYTES   = 4096;
    localparam int          IRQ_N       = 27;
    localparam logic [6:0]  EEPROM_ADDR = 7'h50;
    localparam logic        I2C_WR      = 1'b0;
    localparam logic        I2C_RD      = 1'b1;
    localparam logic [15:0] IMG_BASE    = 16'h0000;
    localparam logic [15:0] PRIV_BASE   = 16'hFF00;
    localparam logic [15:0] PRIV_MASK   = 16'hFF00;
    localparam logic [1:0]  Q_SET       = 2'h0;
    localparam logic [1:0]  Q_RISE      = 2'h1;
    localparam logic [1:0]  Q_SAMP      = 2'h2;
    localparam logic [1:0]  Q_FALL      = 2'h3;
    localparam logic [2:0]  BIT_MSB     = 3'h7;
    localparam logic [1:0]  HDR_HI      = 2'h0;
    localparam logic [1:0]  HDR_LO      = 2'h1;
    localparam logic [1:0]  HDR_RS      = 2'h2;
    localparam logic [1:0]  HDR_RD      = 2'h3;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h0,
        ST_START  = 4'h1,
        ST_WBYTE  = 4'h2,
        ST_WACK   = 4'h3,
        ST_RBYTE  = 4'h4,
        ST_MACK   = 4'h5,
        ST_STOP   = 4'h6,
        ST_DONE   = 4'h7
    } i2c_st_e;
endpackage

// ### boot_eeprom_model.sv
// serial boot memory model answering on the open-drain link
`timescale 1ns/1ns
module boot_eeprom_model #(
    parameter int DEPTH = 8
) (
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic ack_en,
    output logic      sda_pull
);
    logic [7:0]  mem [DEPTH];
    logic [7:0]  sh;
    logic [15:0] ptr;
    logic        rd;
    logic        act;
    int          bitn;
    int          nbyte;
    initial begin
        sda_pull = 1'b0;
        act = 1'b0;
    end
    always @(negedge sda) if (scl) begin
        bitn = 0;
        nbyte = 0;
        rd = 1'b0;
        act = 1'b1;
    end
    always @(posedge sda) if (scl) act = 1'b0;
    always @(posedge scl) if (act) begin
        if (bitn < 8) sh = {sh[6:0], sda};
        else if (rd && sda) act = 1'b0;
        bitn++;
    end
    // released line floats to the pull-up level
    always @(negedge scl) begin
        sda_pull = 1'b0;
        if (act && bitn == 8 && !rd) begin
            if (nbyte > 0 || (sh[7:1] == 7'h50 && ack_en)) sda_pull = 1'b1;
            else act = 1'b0;
            if (nbyte == 0) rd = sh[0];
            if (nbyte == 1) ptr[15:8] = sh;
            if (nbyte == 2) ptr[7:0] = sh;
        end else if (act && bitn == 9) begin
            bitn = 0;
            nbyte++;
            if (rd) begin
                if (nbyte > 1) ptr++;
                sh = mem[ptr % DEPTH];
                sda_pull = ~sh[7];
            end
        end else if (act && rd && bitn < 8) sda_pull = ~sh[7];
    end
endmodule // boot_eeprom_model

// ### tb_top.sv
// self-checking bench for boot load, register arbitration and interrupt routing
`timescale 1ns/1ns
module tb_top;
    localparam int RB = 8;
    localparam int N  = boot_pkg::IRQ_N;
    logic         core_clk, rst_n, boot_memory_present, core_off, mode_standalone;
    logic         core_standby, ack_en, ctrl_req, ctrl_we, ext_req, ext_we, sda_pull;
    logic         scl_o, scl_oe_n, sda_o, sda_oe_n, rom_en, core_rst_n, core_tick;
    logic         boot_done, boot_fail, ctrl_gnt, ext_gnt, ext_err, reg_en, reg_we;
    logic         core_irq, ext_irq, core_run, clk_en;
    logic [7:0]   rom_rd_data, fetch_data, ctrl_wdata, ext_wdata, reg_wdata;
    logic [11:0]  fetch_addr;
    logic [15:0]  ctrl_addr, ext_addr, reg_addr;
    logic [N-1:0] irq_src, irq_enable, irq_route_ext, ctrl_irq_clr, ext_irq_clr;
    logic [7:0]   img [RB];
    int           bad_count, checks_done;
    wire          scl = scl_oe_n | scl_o;
    wire          sda = (sda_oe_n | sda_o) & ~sda_pull;
    boot_load_and_irq_routing #(.RAM_BYTES(RB)) dut_u (.core_clk, .rst_n, .clk_en,
        .boot_memory_present, .core_off, .mode_standalone, .core_standby, .scl_i(scl),
        .scl_o, .scl_oe_n, .sda_i(sda), .sda_o, .sda_oe_n, .fetch_addr, .rom_rd_data,
        .fetch_data, .rom_en, .core_rst_n, .core_tick, .boot_done, .boot_fail, .ctrl_req,
        .ctrl_we, .ctrl_addr, .ctrl_wdata, .ctrl_gnt, .ext_req, .ext_we, .ext_addr,
        .ext_wdata, .ext_gnt, .ext_err, .reg_en, .reg_we, .reg_addr, .reg_wdata, .irq_src,
        .irq_enable, .irq_route_ext, .ctrl_irq_clr, .ext_irq_clr, .core_irq, .ext_irq,
        .core_run);
    boot_eeprom_model #(.DEPTH(RB)) ee_u (.scl(scl), .sda(sda), .ack_en(ack_en),
        .sda_pull(sda_pull));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task do_reset(input logic pres, input logic ack);
        @(posedge core_clk);
        rst_n <= 1'b0;
        boot_memory_present <= pres;
        ack_en <= ack;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        chk("reset_state", 16'h000C, {rom_en, scl_oe_n, core_rst_n, boot_done});
    endtask
    task wait_done;
        int n;
        n = 0;
        while (boot_done !== 1'b1 && n < 40000) begin
            @(posedge core_clk);
            n++;
        end
        if (boot_done !== 1'b1) begin
            chk("boot_timeout", 1, 0);
            test_done();
        end
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task fetch_all(input logic ram);
        logic [7:0] r;
        for (int i = 0; i < RB + 2; i++) begin
            r = 8'($urandom);
            @(posedge core_clk);
            fetch_addr <= 12'(i);
            rom_rd_data <= r;
            @(posedge core_clk);
            #1;
            chk("fetch_data", ram ? (i < RB ? img[i] : 8'h00) : r, fetch_data);
        end
    endtask
    // the controller side writes and the external side reads, each at a random register
    task arb(input logic uc, input logic ue);
        logic [15:0] ca, ea;
        logic        cg, eg;
        int          n;
        ca = 16'($urandom);
        ea = 16'($urandom);
        if ($urandom % 3 == 0) ea[15:8] = 8'hFF;
        cg = !uc;
        eg = !ue;
        n = 0;
        @(posedge core_clk);
        ctrl_req <= uc;
        ctrl_we <= 1'b1;
        ctrl_addr <= ca;
        ctrl_wdata <= ca[15:8];
        ext_req <= ue;
        ext_we <= 1'b0;
        ext_addr <= ea;
        while (!(cg && eg) && n < 4) begin
            @(posedge core_clk);
            if (cg) ctrl_req <= 1'b0;
            if (eg) ext_req <= 1'b0;
            #1;
            n++;
            chk("one_grant", 0, ctrl_gnt & ext_gnt);
            if (ctrl_gnt) begin
                cg = 1'b1;
                chk("ctrl_addr", ca, reg_addr);
                chk("ctrl_wr", {8'h03, ca[15:8]}, {6'h00, reg_en, reg_we, reg_wdata});
            end
            if (ext_gnt) begin
                eg = 1'b1;
                chk("ext_err", ea[15:8] == 8'hFF, ext_err);
                chk("ext_reg_en", ea[15:8] != 8'hFF, reg_en);
                if (ea[15:8] != 8'hFF) chk("ext_addr", ea, reg_addr);
            end
        end
        if (!(cg && eg)) begin
            chk("grant_timeout", 1, 0);
            test_done();
        end
        @(posedge core_clk);
        ctrl_req <= 1'b0;
        ext_req <= 1'b0;
    endtask
    initial begin
        logic [N-1:0] s, e, r;
        int           t;
        bad_count = 0;
        checks_done = 0;
        {rst_n, boot_memory_present, core_off, mode_standalone, core_standby} = '0;
        {ack_en, ctrl_req, ctrl_we, ext_req, ext_we} = '0;
        {fetch_addr, rom_rd_data, ctrl_addr, ctrl_wdata, ext_addr, ext_wdata} = '0;
        {irq_src, irq_enable, irq_route_ext, ctrl_irq_clr, ext_irq_clr} = '0;
        clk_en = 1'b1;
        void'($urandom(48082));
        for (int i = 0; i < RB; i++) begin
            img[i] = 8'($urandom);
            ee_u.mem[i] = img[i];
        end
        do_reset(1'b1, 1'b1);
        for (int k = 0; k < 24; k++) arb(k % 3 != 1, k % 3 != 2);
        chk("core_held", 0, core_rst_n);
        wait_done();
        chk("ram_boot", 16'h0011, {rom_en, boot_fail, core_rst_n, 3'h0, core_run});
        fetch_all(1'b1);
        t = 0;
        repeat (200) begin
            @(posedge core_clk);
            #1;
            t += int'(core_tick);
        end
        chk("tick_count", 1, t >= 31 && t <= 33);
        @(posedge core_clk);
        core_standby <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        chk("core_sleep", 0, core_run);
        @(posedge core_clk);
        irq_src <= N'(1);
        irq_enable <= N'(1);
        repeat (3) @(posedge core_clk);
        #1;
        chk("core_wake", 1, core_run);
        @(posedge core_clk);
        {core_standby, core_off, irq_src, ctrl_irq_clr} <= {2'b01, {N{1'b0}}, {N{1'b1}}};
        repeat (3) @(posedge core_clk);
        #1;
        chk("core_off", 0, core_run);
        @(posedge core_clk);
        {clk_en, core_off, ctrl_irq_clr} <= '0;
        repeat (3) @(posedge core_clk);
        #1;
        chk("frozen", 0, core_run);
        @(posedge core_clk);
        clk_en <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            s = N'($urandom);
            e = (k == 0) ? '0 : N'($urandom & $urandom & $urandom);
            r = (k == 1) ? '1 : N'($urandom);
            @(posedge core_clk);
            {irq_src, irq_enable, irq_route_ext} <= {s, e, r};
            mode_standalone <= (k % 4 == 3);
            @(posedge core_clk);
            irq_src <= '0;
            repeat (2) @(posedge core_clk);
            #1;
            if (k % 4 == 3) r = '0;
            chk("irq_route", {|(s & e & ~r), |(s & e & r)}, {core_irq, ext_irq});
            @(posedge core_clk);
            if (k % 2 == 1) ext_irq_clr <= '1;
            else ctrl_irq_clr <= '1;
            @(posedge core_clk);
            {ext_irq_clr, ctrl_irq_clr} <= '0;
            repeat (2) @(posedge core_clk);
            #1;
            chk("irq_clear", 0, {core_irq, ext_irq});
        end
        // a new event in the same cycle as a clear stays pending
        @(posedge core_clk);
        {mode_standalone, irq_route_ext, irq_src, irq_enable, ext_irq_clr}
            <= {1'b0, {N{1'b0}}, N'(1), N'(1), {N{1'b1}}};
        @(posedge core_clk);
        {irq_src, ext_irq_clr} <= '0;
        repeat (2) @(posedge core_clk);
        #1;
        chk("set_wins", 1, core_irq);
        do_reset(1'b1, 1'b0);
        wait_done();
        chk("nack_boot", 16'h0011, {3'h0, rom_en, 3'h0, boot_fail});
        fetch_all(1'b0);
        do_reset(1'b0, 1'b1);
        wait_done();
        chk("rom_boot", 16'h0010, {3'h0, rom_en, 3'h0, boot_fail});
        fetch_all(1'b0);
        test_done();
    end
endmodule // tb_top
